// ---- core/branch_pkg.sv ----
// package: constants for the carry-conditional relative branch unit
package branch_pkg;
  localparam int          PC_WIDTH        = 21;
  localparam int          WORD_WIDTH      = 16;
  localparam int          OFFSET_WIDTH    = 8;
  localparam logic [7:0]  BRANCH_OPCODE   = 8'hE2;
  localparam int          OPCODE_MSB      = 15;
  localparam int          OPCODE_LSB      = 8;
  localparam logic [20:0] PC_RESET        = 21'h000000;
  localparam logic [20:0] WORD_STEP       = 21'h000002;
  localparam int          TAKEN_CYCLES    = 2;
  localparam int          NOTTAKEN_CYCLES = 1;
  localparam logic        FLAG_CLEAR      = 1'b0;

  typedef enum logic [1:0]
  {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01
  } unit_state_t;
endpackage

// ---- core/branch_if.sv ----
// interface: carries the decoded branch request between decoder and executor
`timescale 1ns/1ns
`default_nettype none
interface branch_if;
  logic        valid;
  logic        carry;
  logic [7:0]  offset;
  logic        take;
  logic        busy;

  modport dec
  (
    output valid,
    output carry,
    output offset,
    input  take,
    input  busy
  );
  modport exe
  (
    input  valid,
    input  carry,
    input  offset,
    output take,
    output busy
  );
endinterface
`default_nettype wire

// ---- core/branch_target_calc.sv ----
// module: combinational target address for a relative branch
`timescale 1ns/1ns
`default_nettype none
module branch_target_calc
  import branch_pkg::*;
#(
  parameter int PCW = PC_WIDTH
)
(
  input  wire logic [PCW-1:0] i_pc_next,
  input  wire logic [7:0]     i_offset,
  output logic      [PCW-1:0] o_target
);
  logic [PCW-1:0] scaled;

  // offset sign-extended then doubled; pc_next already holds own address plus two
  always_comb
  begin
    scaled   = {{(PCW-9){i_offset[7]}}, i_offset, 1'b0};
    o_target = i_pc_next + scaled;
  end
endmodule
`default_nettype wire

// ---- core/branch_if_carry_set_unit.sv ----
// top: branch_if_carry_set execution with program counter sequencing
`timescale 1ns/1ns
`default_nettype none
module branch_if_carry_set_unit
  import branch_pkg::*;
#(
  parameter int PCW = PC_WIDTH
)
(
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_ce,
  input  wire logic [WORD_WIDTH-1:0] i_instr,
  input  wire logic                  i_instr_valid,
  input  wire logic                  i_carry,
  output logic      [PCW-1:0]        o_pc,
  output logic                       o_taken,
  output logic                       o_flush,
  output logic                       o_flags_we
);
  branch_if bus ();

  unit_state_t    state;
  unit_state_t    next_state;
  logic [PCW-1:0] pc;
  logic [PCW-1:0] next_pc;
  logic [PCW-1:0] target;
  logic           taken;
  logic           next_taken;
  logic           flush;
  logic           next_flush;
  // status write enable is a flop too, so every port leaves straight from a register
  logic           flags_we;
  logic           next_flags_we;

  // opcode decode, used by both the request and the checks
  function automatic logic is_branch(input logic [WORD_WIDTH-1:0] w);
    is_branch = (w[OPCODE_MSB:OPCODE_LSB] == BRANCH_OPCODE);
  endfunction

  // decoder side of the carrier; instructions arriving in a flush cycle are dropped
  assign bus.valid  = i_instr_valid && is_branch(i_instr);
  assign bus.carry  = i_carry;
  assign bus.offset = i_instr[OFFSET_WIDTH-1:0];
  // busy masks the refill cycle, so a word offered there can never redirect flow
  assign bus.take   = bus.valid && bus.carry && !bus.busy;
  assign bus.busy   = (state == ST_FLUSH);

  branch_target_calc #(.PCW(PCW)) u_calc
  (
    .i_pc_next (pc + WORD_STEP[PCW-1:0]),
    .i_offset  (bus.offset),
    .o_target  (target)
  );

  // next-state: taken jumps then flushes one cycle, any other valid word outside the flush cycle steps one word, no word holds
  always_comb
  begin
    next_state = state;
    next_pc    = pc;
    next_taken = 1'b0;
    next_flush = 1'b0;
    next_flags_we = FLAG_CLEAR; // branch never touches status
    unique case (state)
      ST_EXEC:
      begin
        if (i_instr_valid)
        begin
          if (bus.take)
          begin
            next_pc    = target;
            next_taken = 1'b1;
            next_flush = 1'b1;
            next_state = ST_FLUSH;
          end
          else
          begin
            next_pc = pc + WORD_STEP[PCW-1:0];
          end
        end
      end
      ST_FLUSH:
      begin
        next_state = ST_EXEC; // refill cycle, pc already holds target
      end
      default:
      begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // state registers; clock enable freezes everything
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state   <= ST_EXEC;
      pc      <= PC_RESET[PCW-1:0];
      taken   <= 1'b0;
      flush   <= 1'b0;
      flags_we <= FLAG_CLEAR;
    end
    else if (i_ce)
    begin
      state   <= next_state;
      pc      <= next_pc;
      taken   <= next_taken;
      flush   <= next_flush;
      flags_we <= next_flags_we;
    end
  end

  assign o_pc       = pc;
  assign o_taken    = taken;
  assign o_flush    = flush;
  assign o_flags_we = flags_we; // the branch never writes status

  // checks
  logic [PCW-1:0] exp_tgt;
  assign exp_tgt = pc + WORD_STEP[PCW-1:0]
                 + {{(PCW-9){i_instr[7]}}, i_instr[7:0], 1'b0};

  // a branch with carry set must jump and enter the refill cycle
  property p_take_carry;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_EXEC && i_instr_valid && is_branch(i_instr) && i_carry)
      |=> (taken && state == ST_FLUSH);
  endproperty
  a_take_carry: assert property (p_take_carry) else $error("carry branch not taken");

  // anything else accepted steps exactly one word and raises no pulse
  property p_notake;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_EXEC && i_instr_valid && !(is_branch(i_instr) && i_carry))
      |=> (!taken && pc == $past(pc) + WORD_STEP[PCW-1:0]);
  endproperty
  a_notake: assert property (p_notake) else $error("sequential step wrong");

  // jump lands on own address plus two plus the doubled offset
  property p_target;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_EXEC && i_instr_valid && is_branch(i_instr) && i_carry)
      |=> (pc == $past(exp_tgt));
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  // negative offset moves backwards; compared as a modular signed distance,
  // since a jump below address zero wraps to the top of the pc range
  property p_back;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && i_instr_valid && is_branch(i_instr) && i_instr[7] && i_carry
      && state == ST_EXEC) |=> ($signed(pc - $past(pc) - WORD_STEP[PCW-1:0]) < 0);
  endproperty
  a_back: assert property (p_back) else $error("negative offset not backward");

  // refill cycle holds the target and returns to execution
  property p_two_cycle;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_FLUSH) |=> (state == ST_EXEC && pc == $past(pc) && !taken);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("flush cycle wrong");

  // status write enable never rises
  property p_noflag;
    @(posedge i_clk) disable iff (i_sys_rst) !o_flags_we;
  endproperty
  a_noflag: assert property (p_noflag) else $error("status written");

  c_taken: cover property (@(posedge i_clk) disable iff (i_sys_rst) taken ##1 !flush);
  c_not: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && i_instr_valid && is_branch(i_instr) && !i_carry && state == ST_EXEC);
  // jump distance stays inside the doubled signed byte around pc plus two
  property p_reach;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_EXEC && i_instr_valid && is_branch(i_instr) && i_carry)
      |=> ($signed(pc - $past(pc) - WORD_STEP[PCW-1:0]) >= -256
        && $signed(pc - $past(pc) - WORD_STEP[PCW-1:0]) <= 254);
  endproperty
  a_reach: assert property (p_reach) else $error("branch distance out of range");

  // pulse lasts one enabled cycle, so the refill never swallows two words
  property p_pulse_once;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && taken) |=> (!taken && !flush);
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("taken pulse too long");

  // a word offered during the refill cycle is dropped and the pc holds
  property p_flush_drop;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && state == ST_FLUSH && i_instr_valid) |=> (pc == $past(pc) && !taken);
  endproperty
  a_flush_drop: assert property (p_flush_drop) else $error("word accepted in refill");

  // with the enable low nothing moves, not even a pending refill
  property p_freeze;
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_ce |=> ($stable(pc) && $stable(state) && $stable(taken) && $stable(flush));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  c_back: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(taken) && $past(i_instr[7]));
  c_drop: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_ce && state == ST_FLUSH && i_instr_valid);
  c_hold: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_ce && taken);
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// testbench: corner and random stimulus for the carry branch unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  import branch_pkg::*;
  logic                  i_clk;
  logic                  i_sys_rst;
  logic                  i_ce;
  logic [WORD_WIDTH-1:0] i_instr;
  logic                  i_instr_valid;
  logic                  i_carry;
  logic [PC_WIDTH-1:0]   o_pc;
  logic                  o_taken;
  logic                  o_flush;
  logic                  o_flags_we;
  logic [PC_WIDTH-1:0]   exp_pc;
  logic                  exp_tk;
  logic [7:0]            corner [5] = '{8'h80, 8'h7F, 8'hFF, 8'h00, 8'h01};
  int                    fails;
  int                    samples_checked;

  branch_if_carry_set_unit #(.PCW(PC_WIDTH)) DUT
  (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_ce          (i_ce),
    .i_instr       (i_instr),
    .i_instr_valid (i_instr_valid),
    .i_carry       (i_carry),
    .o_pc          (o_pc),
    .o_taken       (o_taken),
    .o_flush       (o_flush),
    .o_flags_we    (o_flags_we)
  );

  // 50 ns clock
  always #25 i_clk = ~i_clk;

  task automatic check(input string what, input logic [PC_WIDTH-1:0] seen,
                       input logic [PC_WIDTH-1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // target counts from the given pc plus one word step, offset sign-extended and doubled
  function automatic logic [PC_WIDTH-1:0] target(input logic [PC_WIDTH-1:0] pc,
                                                 input logic [7:0] n);
    return pc + WORD_STEP + {{(PC_WIDTH-9){n[7]}}, n, 1'b0};
  endfunction

  // drive one cycle, advance the model, then check once the edge has landed
  task automatic step(input logic ce, input logic vld, input logic [15:0] ins,
                      input logic cy);
    i_ce = ce;
    i_instr_valid = vld;
    i_instr = ins;
    i_carry = cy;
    if (ce && exp_tk)
      exp_tk = 1'b0;
    else if (ce && vld)
    begin
      exp_tk = (ins[OPCODE_MSB:OPCODE_LSB] == BRANCH_OPCODE) && cy;
      exp_pc = exp_tk ? target(exp_pc, ins[7:0]) : exp_pc + WORD_STEP;
    end
    else if (ce)
      exp_tk = 1'b0;
    @(posedge i_clk);
    #1;
    check("pc", o_pc, exp_pc);
    check("taken", PC_WIDTH'(o_taken), PC_WIDTH'(exp_tk));
    check("flush", PC_WIDTH'(o_flush), PC_WIDTH'(exp_tk));
    check("flags_we", PC_WIDTH'(o_flags_we), PC_WIDTH'(FLAG_CLEAR));
  endtask

  // main sequence: reset, offset corners, random traffic, reset in mid-run
  initial
  begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    i_ce = 1'b0;
    i_instr = 16'h0000;
    i_instr_valid = 1'b0;
    i_carry = 1'b0;
    fails = 0;
    samples_checked = 0;
    exp_pc = PC_RESET;
    exp_tk = 1'b0;
    void'($urandom(32'h2224AF67));
    repeat (5) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    // a branch offered in the flush cycle must be dropped
    foreach (corner[k])
    begin
      step(1'b1, 1'b1, {BRANCH_OPCODE, corner[k]}, 1'b1);
      step(1'b1, 1'b1, {BRANCH_OPCODE, corner[k]}, 1'b1);
      step(1'b1, 1'b1, {BRANCH_OPCODE, corner[k]}, 1'b0);
      step(1'b0, 1'b1, {BRANCH_OPCODE, corner[k]}, 1'b1);
    end
    repeat (2000)
      step($urandom_range(0, 7) != 0, $urandom_range(0, 3) != 0,
           {($urandom_range(0, 1) != 0) ? BRANCH_OPCODE : 8'($urandom), 8'($urandom)},
           1'($urandom));
    step(1'b1, 1'b1, {BRANCH_OPCODE, 8'h10}, 1'b1);
    i_sys_rst = 1'b1;
    exp_pc = PC_RESET;
    exp_tk = 1'b0;
    step(1'b0, 1'b0, 16'h0000, 1'b0);
    i_sys_rst = 1'b0;
    step(1'b1, 1'b1, {BRANCH_OPCODE, 8'hFE}, 1'b1);
    step(1'b1, 1'b0, 16'h0000, 1'b0);
    final_report();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #300000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
